// [rtl/sck_defines.svh]
// constants of the receiver clocking block
`ifndef SCK_DEFINES_SVH
`define SCK_DEFINES_SVH

// core clock and mode bound rates
`define SCK_CLK_HZ 64'd100000000
`define SCK_RATE_192K_HZ 64'd192000
`define SCK_RATE_96K_HZ 64'd96000
`define SCK_RATE_88K2_HZ 64'd88200
`define SCK_RATE_48K_HZ 64'd48000
`define SCK_RATE_44K1_HZ 64'd44100
`define SCK_RATE_32K_HZ 64'd32000
// frame period bounds in core cycles at rate +1% and -1%
`define SCK_CNT_LO(rhz) ((`SCK_CLK_HZ * 64'd100 + (rhz) * 64'd101 - 64'd1) / ((rhz) * 64'd101))
`define SCK_CNT_HI(rhz) ((`SCK_CLK_HZ * 64'd100) / ((rhz) * 64'd99))
// strap settle cycles
`define SCK_STRAP_WAIT 2'h3

// register byte addresses
`define SCK_ADDR_CTRL 8'h00
`define SCK_ADDR_PRESCALE 8'h04
`define SCK_ADDR_SEC_INT 8'h08
`define SCK_ADDR_SEC_FRAC 8'h0C
`define SCK_ADDR_SEC_OUT 8'h10
`define SCK_ADDR_RX_STATUS 8'h14
`define SCK_ADDR_INT_STATUS 8'h18
`define SCK_ADDR_INT_MASK 8'h1C
`define SCK_ADDR_FIRST_PLL 8'h20

// control register fields
`define SCK_CTRL_FIRST_PD 0
`define SCK_CTRL_SECOND_PD 1
`define SCK_CTRL_RX_PD 2
`define SCK_CTRL_XCV_PD 3
`define SCK_CTRL_ROUTE_DAC 4
`define SCK_CTRL_CLK_PIN 5
`define SCK_CTRL_DAC_CLK 6
`define SCK_CTRL_W 7
`define SCK_CTRL_RST 7'h0F
`define SCK_CTRL_HW_RST 7'h70
// prescale register fields
`define SCK_PRE_FIRST 0
`define SCK_PRE_SECOND 1
// second pll output register fields and reset values
`define SCK_OUT_RATIO_LSB 0
`define SCK_OUT_HALVER 2
`define SCK_OUT_RATIO_RST 2'h2
`define SCK_SEC_INT_RST 4'h7
`define SCK_SEC_FRAC_RST 22'h36FD21
`define SCK_SEC_PRE_RST 1'h0
// receiver status fields
`define SCK_STAT_LOCKED 2
`define SCK_STAT_HWMODE 3
// interrupt bits
`define SCK_INT_RATE_CHG 0
`define SCK_INT_W 1
// first pll divider readback split
`define SCK_FIRST_INT_LSB 22

`endif

// [rtl/sck_pkg.sv]
// types shared by the receiver clocking block
package sck_pkg;
    // clocking mode of the incoming stream, none while unlocked
    typedef enum logic [2:0] {
        SCK_MODE_NONE = 3'h0,
        SCK_MODE_1 = 3'h1,
        SCK_MODE_2 = 3'h3,
        SCK_MODE_3 = 3'h2,
        SCK_MODE_4 = 3'h6
    } sck_mode_e;
    // frame period count type
    typedef logic [11:0] sck_cnt_t;
endpackage

// [rtl/sck_pll_clocking.sv]
// receiver clocking control
`timescale 1ns/1ps
`include "sck_defines.svh"
module sck_pll_clocking
    import sck_pkg::*;
#(
    parameter int TRACK_STEP = 64, // fraction step per frame while tracking
    parameter logic [3:0] FIRST_INT_NOM = 4'h8, // first pll integer start value
    parameter logic [21:0] FIRST_FRAC_NOM = 22'h200000, // first pll fraction start value
    parameter int DATA_W = 24 // recovered sample width
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [31:0] regRdData,
    // strap pin
    input wire logic hwModePin,
    // recovered stream
    input wire logic rxFrameStrobe,
    input wire logic [DATA_W-1:0] rxLeftData,
    input wire logic [DATA_W-1:0] rxRightData,
    input wire logic rxSampleValid,
    input wire logic rxPcmAudio,
    // first pll control
    output logic [3:0] firstPllIntegerDiv,
    output logic [21:0] firstPllFractionDiv,
    output logic firstPllInputHalver,
    output logic firstPllPowerDown,
    // second pll control
    output logic [3:0] secondPllIntegerDiv,
    output logic [21:0] secondPllFractionDiv,
    output logic secondPllInputHalver,
    output logic [1:0] secondPllOutRatio,
    output logic secondPllOutHalver,
    output logic secondPllPowerDown,
    // master clock divider
    output logic [1:0] mclkRatio,
    output logic mclkHalver,
    // receiver power
    output logic receiverPowerDown,
    output logic transceiverPowerDown,
    // audio interface data
    output logic [DATA_W-1:0] aifLeftData,
    output logic [DATA_W-1:0] aifRightData,
    output logic aifValid,
    // recovered data to the first dac
    output logic [DATA_W-1:0] dacLeftData,
    output logic [DATA_W-1:0] dacRightData,
    output logic dacValid,
    // recovered clock steering
    output logic recClkPinEnable,
    output logic dacClkFromRx,
    // interrupt
    output logic irq
);
    // control and setup registers
    logic [`SCK_CTRL_W-1:0] ctrl_r; // power downs and routing
    logic firstHalver_r; // first pll input halver
    logic secondHalver_r; // second pll input halver
    logic [3:0] secInt_r; // second pll integer divider
    logic [21:0] secFrac_r; // second pll fraction divider
    logic [1:0] secRatio_r; // user clocking only
    logic secOutHalver_r; // user clocking only
    logic [`SCK_INT_W-1:0] intStatus_r; // sticky events
    logic [`SCK_INT_W-1:0] intMask_r; // event enables
    logic [31:0] rdData_r; // read data

    // strap synchroniser and boot capture
    logic strapMeta_r; // first stage
    logic strapSync_r; // second stage
    logic strapConf_r; // third stage, compared with the second
    logic [1:0] bootCnt_r; // settling wait
    logic bootDone_r; // strap captured
    logic hwMode_r; // pin-controlled mode latched at boot

    // mode tracking
    sck_mode_e mode; // current sorted mode
    sck_mode_e lastMode_r; // last locked mode seen
    sck_cnt_t period; // latest frame period
    sck_cnt_t prevPeriod_r; // period of the frame before
    logic newPeriod; // a locked frame period arrived
    logic rxActive; // receiver path powered
    logic rateChange; // mode change event
    logic [1:0] rateField; // two-bit received rate code
    logic [3:0] firstInt_r; // first pll integer divider
    logic [21:0] firstFrac_r; // first pll fraction divider

    // register strobes decoded once
    logic wrOk; // register mode writes
    assign wrOk = regWrEn && !hwMode_r;

    // receiver runs only with its clock path powered
    assign rxActive = !ctrl_r[`SCK_CTRL_RX_PD] && !ctrl_r[`SCK_CTRL_XCV_PD] && !ctrl_r[`SCK_CTRL_FIRST_PD];

    // frame period sorting
    sck_rate_sort u_sort (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .enable(rxActive),
        .frameStrobe(rxFrameStrobe),
        .mode(mode),
        .period(period),
        .newPeriod(newPeriod)
    );

    // strap pin passes three flops
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            strapMeta_r <= 1'b0;
            strapSync_r <= 1'b0;
            strapConf_r <= 1'b0;
        end else begin
            strapMeta_r <= hwModePin;
            strapSync_r <= strapMeta_r;
            strapConf_r <= strapSync_r;
        end
    end

    // latch the strap mode once the chain has filled
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bootCnt_r <= 2'h0;
            bootDone_r <= 1'b0;
            hwMode_r <= 1'b0;
        end else if (!bootDone_r) begin
            if (bootCnt_r != `SCK_STRAP_WAIT) begin
                bootCnt_r <= bootCnt_r + 2'h1;
            end else if (strapSync_r == strapConf_r) begin
                bootDone_r <= 1'b1;
                hwMode_r <= strapConf_r;
            end
        end
    end

    // control register; strap mode loads all enabled
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_r <= `SCK_CTRL_RST;
        end else if (!bootDone_r && bootCnt_r == `SCK_STRAP_WAIT && strapSync_r == strapConf_r && strapConf_r) begin
            ctrl_r <= `SCK_CTRL_HW_RST;
        end else if (wrOk && regAddr == `SCK_ADDR_CTRL) begin
            ctrl_r <= regWrData[`SCK_CTRL_W-1:0];
        end
    end

    // prescale register; the host keeps both equal
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            firstHalver_r <= `SCK_SEC_PRE_RST;
            secondHalver_r <= `SCK_SEC_PRE_RST;
        end else if (wrOk && regAddr == `SCK_ADDR_PRESCALE) begin
            firstHalver_r <= regWrData[`SCK_PRE_FIRST];
            secondHalver_r <= regWrData[`SCK_PRE_SECOND];
        end
    end

    // second pll dividers, 12 MHz mode 2 to 4 default
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            secInt_r <= `SCK_SEC_INT_RST;
            secFrac_r <= `SCK_SEC_FRAC_RST;
        end else if (wrOk && regAddr == `SCK_ADDR_SEC_INT) begin
            secInt_r <= regWrData[3:0];
        end else if (wrOk && regAddr == `SCK_ADDR_SEC_FRAC) begin
            secFrac_r <= regWrData[21:0];
        end
    end

    // second pll output settings, user clocking only
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            secRatio_r <= `SCK_OUT_RATIO_RST;
            secOutHalver_r <= 1'b0;
        end else if (wrOk && regAddr == `SCK_ADDR_SEC_OUT) begin
            secRatio_r <= regWrData[`SCK_OUT_RATIO_LSB +: 2];
            secOutHalver_r <= regWrData[`SCK_OUT_HALVER];
        end
    end

    // last locked mode, kept over a loss of lock
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lastMode_r <= SCK_MODE_NONE;
        end else if (mode != SCK_MODE_NONE) begin
            lastMode_r <= mode;
        end
    end

    // only a move between two locked modes is an event
    assign rateChange = (mode != SCK_MODE_NONE) && (lastMode_r != SCK_MODE_NONE) && (mode != lastMode_r);

    // sticky status, cleared by writing one; a new event in the clear cycle wins
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            intStatus_r <= '0;
        end else begin
            intStatus_r[`SCK_INT_RATE_CHG] <= rateChange ||
                (intStatus_r[`SCK_INT_RATE_CHG] &&
                 !(regWrEn && regAddr == `SCK_ADDR_INT_STATUS && regWrData[`SCK_INT_RATE_CHG]));
        end
    end

    // interrupt mask
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            intMask_r <= '0;
        end else if (wrOk && regAddr == `SCK_ADDR_INT_MASK) begin
            intMask_r <= regWrData[`SCK_INT_W-1:0];
        end
    end

    // level interrupt until the flag is cleared or masked
    assign irq = |(intStatus_r & intMask_r);

    // two-bit rate code, mode 1 is zero
    always_comb begin
        unique case (mode)
            SCK_MODE_1: rateField = 2'h0;
            SCK_MODE_2: rateField = 2'h1;
            SCK_MODE_3: rateField = 2'h2;
            SCK_MODE_4: rateField = 2'h3;
            default: rateField = 2'h0; // unlocked, see locked bit
        endcase
    end

    // first pll tracking: restart on new mode, then nudge fraction
    // trade-off: a fixed step is slow but never oscillates
    always_ff @(posedge core_clk) begin
        if (!rst_n || !rxActive || mode == SCK_MODE_NONE) begin
            firstInt_r <= FIRST_INT_NOM;
            firstFrac_r <= FIRST_FRAC_NOM;
            prevPeriod_r <= '0;
        end else if (rateChange) begin
            firstInt_r <= FIRST_INT_NOM;
            firstFrac_r <= FIRST_FRAC_NOM;
            prevPeriod_r <= '0;
        end else if (newPeriod) begin
            prevPeriod_r <= period;
            if (prevPeriod_r != '0 && period > prevPeriod_r && firstFrac_r > 22'(TRACK_STEP)) begin
                firstFrac_r <= firstFrac_r - 22'(TRACK_STEP);
            end else if (prevPeriod_r != '0 && period < prevPeriod_r && firstFrac_r < ~22'(TRACK_STEP)) begin
                firstFrac_r <= firstFrac_r + 22'(TRACK_STEP);
            end
        end
    end

    // master clock divider keeps output at 256 fs
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mclkRatio <= 2'h0;
            mclkHalver <= 1'b0;
        end else begin
            unique case (mode)
                SCK_MODE_1: mclkRatio <= 2'h0;
                SCK_MODE_2: mclkRatio <= 2'h1;
                SCK_MODE_3: mclkRatio <= 2'h2;
                SCK_MODE_4: mclkRatio <= 2'h3;
                default: mclkRatio <= mclkRatio; // hold the last ratio while unlocked
            endcase
            mclkHalver <= 1'b0;
        end
    end

    // pll outputs; second pll output fields ignored while receiving
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            firstPllIntegerDiv <= FIRST_INT_NOM;
            firstPllFractionDiv <= FIRST_FRAC_NOM;
            secondPllOutRatio <= `SCK_OUT_RATIO_RST;
            secondPllOutHalver <= 1'b0;
        end else begin
            firstPllIntegerDiv <= firstInt_r;
            firstPllFractionDiv <= firstFrac_r;
            secondPllOutRatio <= rxActive ? `SCK_OUT_RATIO_RST : secRatio_r;
            secondPllOutHalver <= rxActive ? 1'b0 : secOutHalver_r;
        end
    end

    // register copies to the pins
    assign firstPllInputHalver = firstHalver_r;
    assign secondPllInputHalver = secondHalver_r;
    assign secondPllIntegerDiv = secInt_r;
    assign secondPllFractionDiv = secFrac_r;
    assign firstPllPowerDown = ctrl_r[`SCK_CTRL_FIRST_PD];
    assign secondPllPowerDown = ctrl_r[`SCK_CTRL_SECOND_PD];
    assign receiverPowerDown = ctrl_r[`SCK_CTRL_RX_PD];
    assign transceiverPowerDown = ctrl_r[`SCK_CTRL_XCV_PD];
    assign recClkPinEnable = ctrl_r[`SCK_CTRL_CLK_PIN];
    assign dacClkFromRx = ctrl_r[`SCK_CTRL_DAC_CLK];

    // samples to the audio interfaces when locked
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            aifLeftData <= '0;
            aifRightData <= '0;
            aifValid <= 1'b0;
        end else begin
            aifValid <= rxSampleValid && rxActive && mode != SCK_MODE_NONE;
            if (rxSampleValid) begin
                aifLeftData <= rxLeftData;
                aifRightData <= rxRightData;
            end
        end
    end

    // only pcm audio may reach the dac; compressed data would play as noise
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dacLeftData <= '0;
            dacRightData <= '0;
            dacValid <= 1'b0;
        end else begin
            dacValid <= rxSampleValid && rxPcmAudio && rxActive && mode != SCK_MODE_NONE &&
                        ctrl_r[`SCK_CTRL_ROUTE_DAC];
            if (rxSampleValid && rxPcmAudio) begin
                dacLeftData <= rxLeftData;
                dacRightData <= rxRightData;
            end
        end
    end

    // registered read mux, data stands one cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdData_r <= '0;
        end else if (regRdEn) begin
            unique case (regAddr)
                `SCK_ADDR_CTRL: rdData_r <= 32'(ctrl_r);
                `SCK_ADDR_PRESCALE: rdData_r <= 32'({secondHalver_r, firstHalver_r});
                `SCK_ADDR_SEC_INT: rdData_r <= 32'(secInt_r);
                `SCK_ADDR_SEC_FRAC: rdData_r <= 32'(secFrac_r);
                `SCK_ADDR_SEC_OUT: rdData_r <= 32'({secOutHalver_r, secRatio_r});
                `SCK_ADDR_RX_STATUS: rdData_r <= 32'({hwMode_r, mode != SCK_MODE_NONE, rateField});
                `SCK_ADDR_INT_STATUS: rdData_r <= 32'(intStatus_r);
                `SCK_ADDR_INT_MASK: rdData_r <= 32'(intMask_r);
                `SCK_ADDR_FIRST_PLL: rdData_r <= 32'({firstInt_r, firstFrac_r});
                default: rdData_r <= 32'h00000000; // unmapped reads as zero
            endcase
        end else begin
            rdData_r <= 32'h00000000;
        end
    end

    assign regRdData = rdData_r;
endmodule

// [rtl/sck_rate_sort.sv]
// frame period sorting into clocking modes
`timescale 1ns/1ps
`include "sck_defines.svh"
module sck_rate_sort
    import sck_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // control and frame marker
    input wire logic enable,
    input wire logic frameStrobe,
    // result
    output sck_mode_e mode,
    output sck_cnt_t period,
    output logic newPeriod
);
    // mode windows in core cycles
    localparam sck_cnt_t M1_LO = sck_cnt_t'(`SCK_CNT_LO(`SCK_RATE_192K_HZ));
    localparam sck_cnt_t M1_HI = sck_cnt_t'(`SCK_CNT_HI(`SCK_RATE_192K_HZ));
    localparam sck_cnt_t M2_LO = sck_cnt_t'(`SCK_CNT_LO(`SCK_RATE_96K_HZ));
    localparam sck_cnt_t M2_HI = sck_cnt_t'(`SCK_CNT_HI(`SCK_RATE_88K2_HZ));
    localparam sck_cnt_t M3_LO = sck_cnt_t'(`SCK_CNT_LO(`SCK_RATE_48K_HZ));
    localparam sck_cnt_t M3_HI = sck_cnt_t'(`SCK_CNT_HI(`SCK_RATE_44K1_HZ));
    localparam sck_cnt_t M4_LO = sck_cnt_t'(`SCK_CNT_LO(`SCK_RATE_32K_HZ));
    localparam sck_cnt_t M4_HI = sck_cnt_t'(`SCK_CNT_HI(`SCK_RATE_32K_HZ));
    localparam sck_cnt_t CNT_TOP = '1;

    sck_cnt_t cnt_r; // cycles since last frame marker
    sck_mode_e sorted; // mode of the current count

    // window compare
    always_comb begin
        sorted = SCK_MODE_NONE;
        if (cnt_r >= M1_LO && cnt_r <= M1_HI) begin
            sorted = SCK_MODE_1;
        end else if (cnt_r >= M2_LO && cnt_r <= M2_HI) begin
            sorted = SCK_MODE_2;
        end else if (cnt_r >= M3_LO && cnt_r <= M3_HI) begin
            sorted = SCK_MODE_3;
        end else if (cnt_r >= M4_LO && cnt_r <= M4_HI) begin
            sorted = SCK_MODE_4;
        end
    end

    // period counter, sticks at top when frames stop
    always_ff @(posedge core_clk) begin
        if (!rst_n || !enable) begin
            cnt_r <= '0;
        end else if (frameStrobe) begin
            cnt_r <= 12'h001;
        end else if (cnt_r != CNT_TOP) begin
            cnt_r <= cnt_r + 12'h001;
        end
    end

    // per-frame update; a stalled stream drops to none
    always_ff @(posedge core_clk) begin
        if (!rst_n || !enable) begin
            mode <= SCK_MODE_NONE;
            period <= '0;
            newPeriod <= 1'b0;
        end else begin
            newPeriod <= frameStrobe && (sorted != SCK_MODE_NONE);
            if (frameStrobe) begin
                mode <= sorted;
                period <= cnt_r;
            end else if (cnt_r == CNT_TOP) begin
                mode <= SCK_MODE_NONE;
            end
        end
    end
endmodule

// [sim/sck_pll_clocking_props.sv]
// assertion checker for the receiver clocking block
`timescale 1ns/1ps
module sck_pll_clocking_props #(
    parameter logic [3:0] FIRST_INT_NOM = 4'h8, // first pll integer start value
    parameter logic [21:0] FIRST_FRAC_NOM = 22'h200000 // first pll fraction start value
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [31:0] regRdData,
    // stream and recovered data
    input wire logic rxFrameStrobe,
    input wire logic rxSampleValid,
    input wire logic aifValid,
    // pll and power
    input wire logic [3:0] firstPllIntegerDiv,
    input wire logic [21:0] firstPllFractionDiv,
    input wire logic [3:0] secondPllIntegerDiv,
    input wire logic [21:0] secondPllFractionDiv,
    input wire logic [1:0] secondPllOutRatio,
    input wire logic secondPllOutHalver,
    input wire logic firstPllPowerDown,
    input wire logic receiverPowerDown,
    input wire logic transceiverPowerDown,
    // interrupt
    input wire logic irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // receiver powered
    wire logic rxOn = !receiverPowerDown && !transceiverPowerDown && !firstPllPowerDown;
    // writes that may drop irq
    wire logic irqWr = regWrEn && (regAddr == 8'h18 || regAddr == 8'h1C);

    a_rd_data_idle: assert property (!$past(regRdEn) |-> regRdData == 32'h0)
        else $error("read data not zero");
    a_out_forced: assert property (rxOn [*2] |-> secondPllOutRatio == 2'h2 && !secondPllOutHalver)
        else $error("output fields not forced");
    a_aif_follows: assert property (aifValid |-> $past(rxSampleValid))
        else $error("aif valid without a received sample");
    a_data_off: assert property (receiverPowerDown [*2] |-> !aifValid)
        else $error("data while receiver off");
    a_first_start: assert property ($rose(rst_n) |-> firstPllIntegerDiv == FIRST_INT_NOM
        && firstPllFractionDiv == FIRST_FRAC_NOM)
        else $error("first pll start values wrong");
    a_second_reset: assert property ($rose(rst_n) |-> secondPllIntegerDiv == 4'h7
        && secondPllFractionDiv == 22'h36FD21)
        else $error("second pll reset values wrong");
    a_irq_hold: assert property (irq && !irqWr |=> irq)
        else $error("irq dropped without service");
    a_irq_cause: assert property ($rose(irq) |-> $past(rxFrameStrobe, 2) || $past(regWrEn))
        else $error("irq rose without cause");
endmodule

bind sck_pll_clocking sck_pll_clocking_props #(.FIRST_INT_NOM(FIRST_INT_NOM), .FIRST_FRAC_NOM(FIRST_FRAC_NOM))
    i_sck_pll_clocking_props (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .rxFrameStrobe(rxFrameStrobe), .rxSampleValid(rxSampleValid),
    .aifValid(aifValid), .firstPllIntegerDiv(firstPllIntegerDiv), .firstPllFractionDiv(firstPllFractionDiv),
    .secondPllIntegerDiv(secondPllIntegerDiv), .secondPllFractionDiv(secondPllFractionDiv),
    .secondPllOutRatio(secondPllOutRatio), .secondPllOutHalver(secondPllOutHalver),
    .firstPllPowerDown(firstPllPowerDown), .receiverPowerDown(receiverPowerDown),
    .transceiverPowerDown(transceiverPowerDown), .irq(irq));

// [sim/sck_pll_clocking_tb_top.sv]
// self-checking bench
`timescale 1ns/1ps
module sck_pll_clocking_tb_top;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic hwModePin = 1'b0;
    logic rxPcmAudio = 1'b1;
    logic [11:0] framePeriod = 12'h8DC; // 44.1 kHz frame
    logic [31:0] regRdData, rd;
    logic rxFrameStrobe, rxSampleValid, aifValid, dacValid, irq, receiverPowerDown;
    logic [23:0] rxLeftData, rxRightData, aifLeftData, dacLeftData;
    logic [1:0] secondPllOutRatio;
    int n_fail = 0;
    int num_checks = 0;
    // reset table, last one unmapped
    logic [7:0] RA [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h20, 8'h24};
    logic [31:0] RV [9] = '{32'h0F, 32'h0, 32'h7, 32'h36FD21, 32'h2, 32'h0, 32'h0, 32'h2200000, 32'h0};
    // frame periods for modes 3, 1, 2, 4 and their rate codes
    logic [11:0] PER [4] = '{12'h8DC, 12'h209, 12'h412, 12'hC35};
    logic [1:0] CODE [4] = '{2'h2, 2'h0, 2'h1, 2'h3};
    always #5 core_clk = ~core_clk;

    sck_pll_clocking i_sck_pll_clocking (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .hwModePin(hwModePin),
        .rxFrameStrobe(rxFrameStrobe), .rxLeftData(rxLeftData), .rxRightData(rxRightData),
        .rxSampleValid(rxSampleValid), .rxPcmAudio(rxPcmAudio), .firstPllIntegerDiv(), .firstPllFractionDiv(),
        .firstPllInputHalver(), .firstPllPowerDown(), .secondPllIntegerDiv(), .secondPllFractionDiv(),
        .secondPllInputHalver(), .secondPllOutRatio(secondPllOutRatio), .secondPllOutHalver(),
        .secondPllPowerDown(), .mclkRatio(), .mclkHalver(), .receiverPowerDown(receiverPowerDown),
        .transceiverPowerDown(), .aifLeftData(aifLeftData), .aifRightData(), .aifValid(aifValid),
        .dacLeftData(dacLeftData), .dacRightData(), .dacValid(dacValid), .recClkPinEnable(), .dacClkFromRx(),
        .irq(irq));
    sck_src_model i_sck_src_model (.core_clk(core_clk), .rst_n(rst_n), .framePeriod(framePeriod),
        .frameStrobe(rxFrameStrobe), .leftData(rxLeftData), .rightData(rxRightData), .sampleValid(rxSampleValid));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge core_clk);
        regWrEn <= 1'b0;
    endtask
    // one-cycle read, data checked next cycle
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #1 check(what, exp, regRdData);
    endtask
    // count frames at mid-cycle; a hang ends the run
    task automatic frames(input int n);
        int k;
        k = 0;
        while (n > 0 && k < 20000) begin
            @(negedge core_clk);
            k++;
            if (rxFrameStrobe === 1'b1) n--;
        end
        if (n > 0) begin
            check("frame wait", 32'h0, 32'h1);
            give_verdict();
        end
    endtask
    // change period at a frame boundary
    task automatic set_rate(input logic [11:0] p);
        frames(1);
        @(posedge core_clk);
        framePeriod <= p;
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++) rdchk("reset value", RA[i], RV[i]);
        $display("test reset values done");
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h7);
        wr(8'h0C, 32'h36FD21);
        wr(8'h00, 32'h0C);
        wr(8'h00, 32'h10);
        wr(8'h10, 32'h5);
        #1 check("out ratio", 32'h2, {30'h0, secondPllOutRatio});
        for (int i = 0; i < 4; i++) begin
            wr(8'h1C, {31'h0, i != 3});
            set_rate(PER[i]);
            frames(3);
            rdchk("rate status", 8'h14, {29'h0, 1'b1, CODE[i]});
            rdchk("mode flag", 8'h18, {31'h0, i > 0});
            check("irq masked", {31'h0, i == 1 || i == 2}, {31'h0, irq});
            wr(8'h1C, 32'h1);
            #1 check("irq unmasked", {31'h0, i > 0}, {31'h0, irq});
            wr(8'h08, i == 1 ? 32'h8 : 32'h7);
            wr(8'h0C, i == 1 ? 32'hC49BA : 32'h36FD21);
            rdchk("second frac", 8'h0C, i == 1 ? 32'hC49BA : 32'h36FD21);
            wr(8'h18, 32'h1);
            #1 check("irq cleared", 32'h0, {31'h0, irq});
            rdchk("flag cleared", 8'h18, 32'h0);
        end
        $display("test rate modes done");
        frames(1);
        rd = {8'h0, rxLeftData};
        @(posedge core_clk);
        #1 check("aif left", rd, {8'h0, aifLeftData});
        check("dac left", rd, {8'h0, dacLeftData});
        check("data valid", 32'h3, {30'h0, aifValid, dacValid});
        $display("test data routing done");
        @(posedge core_clk);
        rst_n <= 1'b0;
        hwModePin <= 1'b1;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge core_clk);
        wr(8'h00, 32'h0F);
        rdchk("strap ctrl", 8'h00, 32'h70);
        frames(3);
        rdchk("strap status", 8'h14, 32'hF);
        check("strap power", 32'h0, {31'h0, receiverPowerDown});
        $display("test strap mode done");
        give_verdict();
    end
endmodule

// [sim/sck_src_model.sv]
// stream source model
`timescale 1ns/1ps
module sck_src_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // frame period in core cycles
    input wire logic [11:0] framePeriod,
    // stream towards the block
    output logic frameStrobe,
    output logic [23:0] leftData,
    output logic [23:0] rightData,
    output logic sampleValid
);
    logic [11:0] cnt_r; // cycles since the last frame
    logic [23:0] smp_r; // running sample value
    // >= ends a frame at once when the period shrinks
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_r <= 12'h000;
            smp_r <= 24'h000001;
        end else if (cnt_r >= framePeriod - 12'h001) begin
            cnt_r <= 12'h000;
            smp_r <= smp_r + 24'h000101;
        end else begin
            cnt_r <= cnt_r + 12'h001;
        end
    end
    assign frameStrobe = rst_n && (cnt_r == framePeriod - 12'h001);
    assign sampleValid = frameStrobe;
    // data churn outside the slot so stale values never look valid
    assign leftData = sampleValid ? smp_r : {cnt_r, ~cnt_r};
    assign rightData = sampleValid ? ~smp_r : {~cnt_r, cnt_r};
endmodule
